//--- verilog/uief_pkg.sv
// Behaviour
// [RULE_01] Each received frame-start packet loads its 11-bit frame number, wrapping at 2048.
// [RULE_02] A missing frame-start packet still raises the frame-start event from a local timer.
// [RULE_03] All isochronous endpoints share one frame-start request and one interrupt line.
// [RULE_04] Frame count reads back as a low byte and a high byte register.
// [RULE_05] Sixteen isochronous endpoints: IN 8 to 15 and OUT 8 to 15.
// [RULE_06] 1024 bytes shared among endpoints; each FIFO placed by a programmable start address.
// [RULE_07] Buffer is 2048 bytes, double-buffered, apart from processor memory.
// [RULE_08] One byte port per endpoint: writes append to IN tail, reads pop OUT head.
// [RULE_09] An endpoint takes part in transfers only while its valid bit is set.
// [RULE_10] Empty IN endpoint: silent when zero-length bit is 0, else sends zero-length packet.
// [RULE_11] One zero-length bit in the pairing register covers all eight IN endpoints.
// [RULE_12] Bytes written to an IN port in a frame are sent, exactly, next frame.
// [RULE_13] Buffer halves swap at every frame start, without retry.
// [RULE_14] Frame-start flag clears on writing 1; writing 0 leaves it.
// [RULE_15] Frame-start request drives the shared interrupt line, cleared separately by software.
// [RULE_16] After each frame start the processor sees empty IN FIFOs.
// [RULE_17] Host sync-frame request uses type 0x82, code 0x0C, length 2, endpoint index.
// [RULE_18] Firmware answers sync-frame with a future frame count, read from frame registers.
// [RULE_19] IN setup order: valid bit, start address, zero-length choice, then interrupt enable.
// [RULE_20] After frame start each OUT FIFO shows last frame's data and 10-bit count.
// [RULE_21] Start addresses written by software have their two low bits zero.
// [RULE_22] OUT data from the host goes into the inactive half from the start address.
// [RULE_23] OUT data with bad CRC is kept and flagged per endpoint.
package uief_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_EP = 8;
  localparam int HALF_BYTES = 1024;
  localparam int MEM_BYTES = 2 * HALF_BYTES;

  // ==========================================================================
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_PAIRING = 8'h00;
  localparam logic [7:0] OFS_EP_VALID = 8'h04;
  localparam logic [7:0] OFS_FRAME_LO = 8'h08;
  localparam logic [7:0] OFS_FRAME_HI = 8'h0c;
  localparam logic [7:0] OFS_SOF_FLAG = 8'h10;
  localparam logic [7:0] OFS_SOF_IE = 8'h14;
  localparam logic [7:0] OFS_USB_IRQ = 8'h18;
  localparam logic [7:0] OFS_ISO_ERR = 8'h1c;
  localparam logic [7:0] OFS_START_BASE = 8'h40;
  localparam logic [7:0] OFS_IN_DATA_BASE = 8'h80;
  localparam logic [7:0] OFS_OUT_DATA_BASE = 8'ha0;
  localparam logic [7:0] OFS_OUT_BC_BASE = 8'hc0;

  // ==========================================================================
  // Reset values
  localparam logic ZLO_RST = 1'b0;
  localparam logic [7:0] EP_VALID_RST = 8'h00;
  localparam logic [7:0] START_RST = 8'h00;
  localparam logic [9:0] CNT_MAX = 10'h3ff;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int FRAME_PERIOD_NS = 1000000;
  localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SOF_MARGIN_NS = 2000;
  localparam int SOF_MARGIN_CYCLES = SOF_MARGIN_NS / CLK_PERIOD_NS;

  typedef enum logic {TX_IDLE, TX_SEND} uief_tx_state_t;

endpackage

//--- verilog/uief_core.sv
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
module uief_core import uief_pkg::*; #(
  parameter int FRAME_TICKS = FRAME_CYCLES,
  parameter int MARGIN_TICKS = SOF_MARGIN_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Frame start from the link
  input wire logic sof_valid,
  input wire logic [10:0] sof_frame,
  // Tokens from the link
  input wire logic tok_valid,
  input wire logic tok_is_in,
  input wire logic [3:0] tok_ep,
  // OUT data from the link
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic rx_crc_err,
  // IN data to the link
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic tx_zlp,
  // Processor interrupt
  output logic usb_cpu_interrupt_line
);

  function automatic logic [9:0] fifo_addr(input logic [7:0] st, input logic [9:0] off);
    // Low two bits of the start value are assumed zero by software
    return {st[7:2], 4'h0} + off;
  endfunction

  function automatic logic in_region(input logic [7:0] a, input logic [7:0] base);
    return a[7:5] == base[7:5];
  endfunction

  // ==========================================================================
  // State
  logic [7:0] start_q [16];
  logic [7:0] mem [MEM_BYTES];
  logic zlo_q;
  logic [7:0] in_valid_q;
  logic [7:0] out_valid_q;
  logic [10:0] frame_q;
  logic sof_flag_q;
  logic sof_ie_q;
  logic usb_irq_q;
  logic [7:0][9:0] in_cnt_q;
  logic [7:0][9:0] in_len_q;
  logic [7:0][9:0] out_cnt_q;
  logic [7:0][9:0] out_rx_q;
  logic [7:0][9:0] out_rd_q;
  logic [7:0] err_link_q;
  logic [7:0] err_cpu_q;
  logic half_q;
  logic [31:0] frame_tmr_q;
  logic sof_seen_q;
  logic wr_q;
  logic rd_q;
  logic rd_done_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  uief_tx_state_t tx_state_q;
  logic [2:0] tx_ep_q;
  logic [9:0] tx_ptr_q;
  logic [9:0] tx_left_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic tx_zlp_q;
  logic rx_active_q;
  logic [2:0] rx_ep_q;

  // ==========================================================================
  // Frame events
  logic sof_synth;
  logic sof_evt;
  // [RULE_02] missed frame fill-in
  assign sof_synth = sof_seen_q & ~sof_valid
                     & (frame_tmr_q == 32'(FRAME_TICKS + MARGIN_TICKS - 1));
  assign sof_evt = sof_valid | sof_synth;

  // ==========================================================================
  // Bus decode
  logic addr_ph;
  logic rd_fire;
  logic [2:0] a_ep;
  logic [3:0] a_start;
  logic in_wr;
  logic out_rd;
  logic w_one;
  logic [9:0] in_wr_addr;
  logic [9:0] out_rd_addr;
  logic [7:0] out_byte;
  logic [31:0] rd_mux;

  assign addr_ph = hsel & htrans[1] & hready;
  // One wait state on every read so read data leave a flip-flop
  assign hreadyout = ~(rd_q & ~rd_done_q);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign rd_fire = rd_q & ~rd_done_q;
  assign a_ep = addr_q[4:2];
  assign a_start = addr_q[5:2];
  assign w_one = hwdata[0];
  // [RULE_08] byte data ports
  assign in_wr = wr_q & in_region(addr_q, OFS_IN_DATA_BASE);
  assign out_rd = rd_fire & in_region(addr_q, OFS_OUT_DATA_BASE);
  assign in_wr_addr = fifo_addr(start_q[{1'b1, a_ep}], in_cnt_q[a_ep]);
  assign out_rd_addr = fifo_addr(start_q[{1'b0, a_ep}], out_rd_q[a_ep]);
  assign out_byte = mem[{half_q, out_rd_addr}];

  // [RULE_18] frame count for firmware
  // [RULE_04] frame count in two bytes
  assign rd_mux =
    (addr_q == OFS_PAIRING) ? {31'h0, zlo_q} :
    (addr_q == OFS_EP_VALID) ? {16'h0, out_valid_q, in_valid_q} :
    (addr_q == OFS_FRAME_LO) ? {24'h0, frame_q[7:0]} :
    (addr_q == OFS_FRAME_HI) ? {29'h0, frame_q[10:8]} :
    (addr_q == OFS_SOF_FLAG) ? {31'h0, sof_flag_q} :
    (addr_q == OFS_SOF_IE) ? {31'h0, sof_ie_q} :
    (addr_q == OFS_USB_IRQ) ? {31'h0, usb_irq_q} :
    (addr_q == OFS_ISO_ERR) ? {24'h0, err_cpu_q} :
    (addr_q[7:6] == OFS_START_BASE[7:6]) ? {24'h0, start_q[a_start]} :
    in_region(addr_q, OFS_OUT_DATA_BASE) ? {24'h0, out_byte} :
    in_region(addr_q, OFS_OUT_BC_BASE) ? {22'h0, out_cnt_q[a_ep]} :
    32'h0;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rd_done_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0;
    end else begin
      if (addr_ph) begin
        wr_q <= hwrite;
        rd_q <= ~hwrite;
        addr_q <= haddr[7:0];
      end else if (hready) begin
        wr_q <= 1'b0;
        rd_q <= 1'b0;
      end
      rd_done_q <= rd_fire;
      if (rd_fire) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // ==========================================================================
  // Control registers
  // [RULE_19] setup steps, plain writes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      zlo_q <= ZLO_RST;
      in_valid_q <= EP_VALID_RST;
      out_valid_q <= EP_VALID_RST;
      sof_ie_q <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        start_q[i] <= START_RST;
      end
    end else if (wr_q) begin
      // [RULE_11] one bit for all IN endpoints
      if (addr_q == OFS_PAIRING) begin
        zlo_q <= hwdata[0];
      end
      if (addr_q == OFS_EP_VALID) begin
        in_valid_q <= hwdata[7:0];
        out_valid_q <= hwdata[15:8];
      end
      if (addr_q == OFS_SOF_IE) begin
        sof_ie_q <= hwdata[0];
      end
      // [RULE_06] programmable FIFO placement
      if (addr_q[7:6] == OFS_START_BASE[7:6]) begin
        start_q[a_start] <= hwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Frame counter, flag and interrupt line
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_q <= 11'h000;
      frame_tmr_q <= 32'h0;
      sof_seen_q <= 1'b0;
      sof_flag_q <= 1'b0;
      usb_irq_q <= 1'b0;
    end else begin
      // [RULE_01] capture frame number
      if (sof_valid) begin
        frame_q <= sof_frame;
        frame_tmr_q <= 32'h0;
        sof_seen_q <= 1'b1;
      end else if (sof_synth) begin
        frame_q <= frame_q + 11'h001;
        // Restart inside the margin so the next real packet is still expected
        frame_tmr_q <= 32'(MARGIN_TICKS);
      end else if (sof_seen_q) begin
        frame_tmr_q <= frame_tmr_q + 32'h1;
      end
      // [RULE_14] write one to clear, set wins
      if (sof_evt) begin
        sof_flag_q <= 1'b1;
      end else if (wr_q && addr_q == OFS_SOF_FLAG && w_one) begin
        sof_flag_q <= 1'b0;
      end
      // [RULE_15] shared line, cleared on its own
      if (sof_evt && sof_ie_q) begin
        usb_irq_q <= 1'b1;
      end else if (wr_q && addr_q == OFS_USB_IRQ && w_one) begin
        usb_irq_q <= 1'b0;
      end
    end
  end
  // [RULE_03] single request for all endpoints
  assign usb_cpu_interrupt_line = usb_irq_q;

  // ==========================================================================
  // Buffer swap and byte counts
  logic rx_wr;
  logic [9:0] rx_wr_addr;
  assign rx_wr = rx_valid & rx_active_q;
  assign rx_wr_addr = fifo_addr(start_q[{1'b0, rx_ep_q}], out_rx_q[rx_ep_q]);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      half_q <= 1'b0;
      in_cnt_q <= '0;
      in_len_q <= '0;
      out_cnt_q <= '0;
      out_rx_q <= '0;
      out_rd_q <= '0;
      err_link_q <= 8'h00;
      err_cpu_q <= 8'h00;
    end else begin
      // [RULE_13] swap every frame, no retry
      half_q <= half_q ^ sof_evt;
      for (int i = 0; i < NUM_EP; i++) begin
        if (sof_evt) begin
          // [RULE_16] fresh empty IN FIFOs
          in_cnt_q[i] <= 10'h000;
          // [RULE_12] last frame's count is sent
          in_len_q[i] <= in_cnt_q[i];
          // [RULE_20] OUT count handed over
          out_cnt_q[i] <= out_rx_q[i];
          out_rx_q[i] <= 10'h000;
          out_rd_q[i] <= 10'h000;
          err_cpu_q[i] <= err_link_q[i];
          err_link_q[i] <= 1'b0;
        end else begin
          if (in_wr && a_ep == 3'(i) && in_cnt_q[i] != CNT_MAX) begin
            in_cnt_q[i] <= in_cnt_q[i] + 10'h001;
          end
          if (out_rd && a_ep == 3'(i) && out_rd_q[i] != out_cnt_q[i]) begin
            out_rd_q[i] <= out_rd_q[i] + 10'h001;
          end
          if (rx_wr && rx_ep_q == 3'(i) && out_rx_q[i] != CNT_MAX) begin
            out_rx_q[i] <= out_rx_q[i] + 10'h001;
          end
          // [RULE_23] bad CRC kept and flagged
          if (rx_end && rx_active_q && rx_crc_err && rx_ep_q == 3'(i)) begin
            err_link_q[i] <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================================
  // Shared buffer memory: processor half and link half never coincide
  // [RULE_07] double buffer, own space
  always_ff @(posedge core_clk) begin
    if (in_wr && in_cnt_q[a_ep] != CNT_MAX) begin
      mem[{half_q, in_wr_addr}] <= hwdata[7:0];
    end
    // [RULE_22] OUT data into link half
    if (rx_wr) begin
      mem[{~half_q, rx_wr_addr}] <= rx_data;
    end
  end

  // ==========================================================================
  // Link side: OUT reception
  logic tok_hit;
  assign tok_hit = tok_valid & tok_ep[3] & ~sof_evt;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_active_q <= 1'b0;
      rx_ep_q <= 3'h0;
    end else if (sof_evt || rx_end) begin
      rx_active_q <= 1'b0;
    end else if (tok_hit && !tok_is_in) begin
      // [RULE_09] only valid endpoints receive
      rx_active_q <= out_valid_q[tok_ep[2:0]];
      rx_ep_q <= tok_ep[2:0];
    end
  end

  // ==========================================================================
  // Link side: IN transmission
  logic tok_in_ok;
  logic [9:0] tok_len;
  logic [2:0] tx_src_ep;
  logic [9:0] tx_src_ptr;
  logic [7:0] tx_byte;

  // [RULE_05] endpoints 8 to 15 only
  assign tok_in_ok = tok_hit & tok_is_in & in_valid_q[tok_ep[2:0]] & (tx_state_q == TX_IDLE);
  assign tok_len = in_len_q[tok_ep[2:0]];
  assign tx_src_ep = (tx_state_q == TX_IDLE) ? tok_ep[2:0] : tx_ep_q;
  assign tx_src_ptr = (tx_state_q == TX_IDLE) ? 10'h000 : tx_ptr_q;
  assign tx_byte = mem[{~half_q, fifo_addr(start_q[{1'b1, tx_src_ep}], tx_src_ptr)}];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_q <= TX_IDLE;
      tx_ep_q <= 3'h0;
      tx_ptr_q <= 10'h000;
      tx_left_q <= 10'h000;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_zlp_q <= 1'b0;
    end else begin
      tx_zlp_q <= 1'b0;
      case (tx_state_q)
        TX_IDLE: begin
          if (tok_in_ok && tok_len != 10'h000) begin
            tx_state_q <= TX_SEND;
            tx_ep_q <= tok_ep[2:0];
            tx_ptr_q <= 10'h001;
            tx_left_q <= tok_len;
            tx_valid_q <= 1'b1;
            tx_data_q <= tx_byte;
          end else if (tok_in_ok && zlo_q) begin
            // [RULE_10] zero-length only when enabled
            tx_zlp_q <= 1'b1;
          end
        end
        TX_SEND: begin
          // A frame start ends the packet: the half is gone
          if (sof_evt) begin
            tx_state_q <= TX_IDLE;
            tx_valid_q <= 1'b0;
          end else if (tx_ready) begin
            if (tx_left_q == 10'h001) begin
              tx_state_q <= TX_IDLE;
              tx_valid_q <= 1'b0;
            end else begin
              tx_data_q <= tx_byte;
              tx_ptr_q <= tx_ptr_q + 10'h001;
              tx_left_q <= tx_left_q - 10'h001;
            end
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
          tx_valid_q <= 1'b0;
        end
      endcase
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign tx_last = tx_valid_q & (tx_left_q == 10'h001);
  assign tx_zlp = tx_zlp_q;

  // ==========================================================================
  // Assertions
  property p_frame_capture;
    @(posedge core_clk) disable iff (!arst_n)
    sof_valid |=> frame_q == $past(sof_frame);
  endproperty
  a_frame_capture: assert property (p_frame_capture) // [RULE_01]
    else $error("frame number not captured");

  property p_missed_sof;
    @(posedge core_clk) disable iff (!arst_n)
    sof_synth |=> sof_flag_q && frame_q == $past(frame_q) + 11'h001;
  endproperty
  a_missed_sof: assert property (p_missed_sof) // [RULE_02]
    else $error("missed frame not filled in");

  property p_irq_line;
    @(posedge core_clk) disable iff (!arst_n)
    sof_evt && sof_ie_q |=> usb_cpu_interrupt_line;
  endproperty
  a_irq_line: assert property (p_irq_line) // [RULE_15]
    else $error("interrupt line not raised");

  property p_flag_w1c;
    @(posedge core_clk) disable iff (!arst_n)
    wr_q && addr_q == OFS_SOF_FLAG && !sof_evt |=> sof_flag_q == ($past(sof_flag_q) & ~$past(w_one));
  endproperty
  a_flag_w1c: assert property (p_flag_w1c) // [RULE_14]
    else $error("flag write behaviour wrong");

  property p_frame_low;
    @(posedge core_clk) disable iff (!arst_n)
    rd_fire && addr_q == OFS_FRAME_LO |=> hreadyout && hrdata[7:0] == $past(frame_q[7:0]);
  endproperty
  a_frame_low: assert property (p_frame_low) // [RULE_04]
    else $error("frame low byte wrong");

  property p_swap;
    @(posedge core_clk) disable iff (!arst_n)
    sof_evt |=> half_q != $past(half_q) && in_cnt_q == '0;
  endproperty
  a_swap: assert property (p_swap) // [RULE_13]
    else $error("no swap at frame start");

  property p_out_count;
    @(posedge core_clk) disable iff (!arst_n)
    sof_evt |=> out_cnt_q == $past(out_rx_q) && out_rd_q == '0;
  endproperty
  a_out_count: assert property (p_out_count) // [RULE_20]
    else $error("OUT count not handed over");

  property p_invalid_silent;
    @(posedge core_clk) disable iff (!arst_n)
    tok_valid && tok_is_in && !in_valid_q[tok_ep[2:0]] && tx_state_q == TX_IDLE
      |=> !tx_valid && !tx_zlp;
  endproperty
  a_invalid_silent: assert property (p_invalid_silent) // [RULE_09]
    else $error("disabled endpoint answered");

  property p_zlp;
    @(posedge core_clk) disable iff (!arst_n)
    tok_in_ok && tok_len == 10'h000 |=> tx_zlp == $past(zlo_q) && !tx_valid;
  endproperty
  a_zlp: assert property (p_zlp) // [RULE_10]
    else $error("empty IN answer wrong");

  property p_in_len;
    @(posedge core_clk) disable iff (!arst_n)
    tok_in_ok && tok_len != 10'h000 |=> tx_valid && tx_left_q == $past(tok_len);
  endproperty
  a_in_len: assert property (p_in_len) // [RULE_12]
    else $error("IN length wrong");

endmodule // uief_core

//--- dv/uief_host_model.sv
module uief_host_model (
  // Clock
  input wire logic core_clk,
  // Frame start and tokens
  output logic sof_valid,
  output logic [10:0] sof_frame,
  output logic tok_valid,
  output logic tok_is_in,
  output logic [3:0] tok_ep,
  // OUT data
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_crc_err,
  // IN data
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_zlp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow = 1'b0;
  logic zlp_seen = 1'b0;
  logic last_seen = 1'b0;
  logic [7:0] rxq[$];
  initial begin
    sof_valid = 1'b0;
    sof_frame = 11'h000;
    tok_valid = 1'b0;
    tok_is_in = 1'b0;
    tok_ep = 4'h0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    rx_crc_err = 1'b0;
    tx_ready = 1'b0;
  end
  // Idle lines show the inverse so a stale value is never mistaken for data
  task sof(input logic [10:0] f);
    sof_valid <= 1'b1;
    sof_frame <= f;
    @(posedge core_clk);
    sof_valid <= 1'b0;
    sof_frame <= ~f;
  endtask
  task tok(input logic is_in, input logic [3:0] ep);
    tok_valid <= 1'b1;
    tok_is_in <= is_in;
    tok_ep <= ep;
    @(posedge core_clk);
    tok_valid <= 1'b0;
    tok_ep <= ~ep;
  endtask
  task out_pkt(input logic [3:0] ep, input int n, input logic [7:0] b, input logic crc);
    tok(1'b0, ep);
    for (int k = 0; k < n; k++) begin
      rx_valid <= 1'b1;
      rx_data <= b + 8'(k);
      @(posedge core_clk);
    end
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    rx_crc_err <= crc;
    @(posedge core_clk);
    rx_end <= 1'b0;
    rx_crc_err <= 1'b0;
  endtask
  // Slow mode stalls every other cycle, as a busy link would
  task in_pkt(input logic [3:0] ep);
    int k;
    rxq.delete();
    zlp_seen = 1'b0;
    k = 0;
    tok(1'b1, ep);
    tx_ready <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
      if (tx_zlp === 1'b1) zlp_seen = 1'b1;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) rxq.push_back(tx_data);
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end while (k < 20 && !(tx_valid === 1'b1 && tx_ready === 1'b1 && tx_last === 1'b1));
    last_seen = (tx_valid === 1'b1) && (tx_ready === 1'b1) && (tx_last === 1'b1);
    tx_ready <= 1'b0;
  endtask
endmodule // uief_host_model

//--- dv/usb_iso_endpoint_fifo_tb_top.sv
module usb_iso_endpoint_fifo_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FT = 2000;
  logic core_clk, arst_n, hsel, hwrite, hreadyout, hresp, irq;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rv;
  logic sv, tv, ti, rxv, rxe, rxc, txr, txv, txl, txz;
  logic [10:0] sf;
  logic [3:0] te;
  logic [7:0] rxd, txd;
  int err_count = 0;
  int n_compared = 0;
  uief_core #(.FRAME_TICKS(FT), .MARGIN_TICKS(10)) uut (.core_clk(core_clk), .arst_n(arst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sof_valid(sv), .sof_frame(sf), .tok_valid(tv), .tok_is_in(ti),
    .tok_ep(te), .rx_valid(rxv), .rx_data(rxd), .rx_end(rxe), .rx_crc_err(rxc),
    .tx_ready(txr), .tx_valid(txv), .tx_data(txd), .tx_last(txl), .tx_zlp(txz),
    .usb_cpu_interrupt_line(irq));
  uief_host_model host (.core_clk(core_clk), .sof_valid(sv), .sof_frame(sf), .tok_valid(tv),
    .tok_is_in(ti), .tok_ep(te), .rx_valid(rxv), .rx_data(rxd), .rx_end(rxe),
    .rx_crc_err(rxc), .tx_ready(txr), .tx_valid(txv), .tx_data(txd), .tx_last(txl),
    .tx_zlp(txz));
  always #10ns core_clk = ~core_clk;
  // ==========================================================================
  // Bus tasks
  task finish_test;
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hsize <= 3'h2;
    hwrite <= w;
    haddr <= a;
    do begin
      @(posedge core_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hsize <= 3'h0;
    hwdata <= d;
    do begin
      @(posedge core_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    rv = hrdata;
    cmp({31'h0, hresp}, 32'h0);
    if (i >= 50) begin
      err_count++;
      $display("[ERR] %0t bus wait ran out", $time);
      finish_test();
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task ck(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rv, e);
  endtask
  // Checks the last IN answer: byte count, zero-length pulse, last flag, and every byte counting up from the first
  task ck_in(input int n, input logic z, input logic [7:0] b);
    cmp(32'(host.rxq.size()), 32'(n));
    cmp({31'h0, host.zlp_seen}, {31'h0, z});
    cmp({31'h0, host.last_seen}, {31'h0, (n != 0)});
    for (int k = 0; k < n && k < host.rxq.size(); k++) cmp({24'h0, host.rxq[k]}, 32'(b + k));
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    ck(12'h000, 32'h0);
    ck(12'h004, 32'h0);
    wr(12'h030, 32'hffff_ffff);
    ck(12'h030, 32'h0);
    wr(12'h004, 32'h0000_0103);
    wr(12'h040, 32'h0000_0000);
    wr(12'h060, 32'h0000_0040);
    wr(12'h064, 32'h0000_0050);
    wr(12'h000, 32'h0);
    wr(12'h014, 32'h1);
    host.sof(11'h7ff);
    ck(12'h008, 32'hff);
    ck(12'h00c, 32'h7);
    cmp({31'h0, irq}, 32'h1);
    wr(12'h010, 32'h0);
    ck(12'h010, 32'h1);
    wr(12'h010, 32'h1);
    ck(12'h010, 32'h0);
    wr(12'h018, 32'h1);
    ck(12'h018, 32'h0);
    for (int k = 0; k < 3; k++) wr(12'h080, 32'(8'ha0 + k));
    wr(12'h084, 32'h55);
    host.out_pkt(4'h8, 3, 8'h30, 1'b1);
    host.out_pkt(4'h9, 2, 8'h60, 1'b0);
    host.sof(11'h000);
    ck(12'h008, 32'h0);
    ck(12'h00c, 32'h0);
    host.slow = 1'b1;
    host.in_pkt(4'h8);
    ck_in(3, 1'b0, 8'ha0);
    ck(12'h0c0, 32'h3);
    for (int k = 0; k < 3; k++) ck(12'h0a0, 32'(8'h30 + k));
    ck(12'h01c, 32'h1);
    ck(12'h0c4, 32'h0);
    host.sof(11'h001);
    host.in_pkt(4'h8);
    ck_in(0, 1'b0, 8'h00);
    wr(12'h000, 32'h1);
    host.in_pkt(4'h9);
    ck_in(0, 1'b1, 8'h00);
    host.in_pkt(4'ha);
    ck_in(0, 1'b0, 8'h00);
    ck(12'h0c0, 32'h0);
    ck(12'h01c, 32'h0);
    wr(12'h010, 32'h1);
    wr(12'h018, 32'h1);
    repeat (FT + 30) @(posedge core_clk);
    ck(12'h008, 32'h2);
    ck(12'h010, 32'h1);
    cmp({31'h0, irq}, 32'h1);
    ck(12'h108, 32'h2);
    host.in_pkt(4'h0);
    ck_in(0, 1'b0, 8'h00);
    // Second reset in mid-run: registers back to their reset values, buffer memory kept
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    cmp({31'h0, irq}, 32'h0);
    ck(12'h004, 32'h0);
    ck(12'h000, 32'h0);
    finish_test();
  end
endmodule // usb_iso_endpoint_fifo_tb_top
